// [hw/icip_fifo.sv]
module icip_fifo
  import icip_pkg::*;
#(
  parameter int unsigned WIDTH = ITEM_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic     core_clk_in, // System clock
  input wire logic     sys_rst_in,  // Synchronous reset, high
  input wire logic     ce_in,       // Clock enable
  icip_stream_if.store st           // Push and pop sides
);

  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
    $error("icip_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW:0]      count_q;
  logic             out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  logic             push;
  logic             load;

  assign st.push_ready = (count_q != CNT_FULL);
  assign push = st.push_valid && st.push_ready;
  assign load = (count_q != '0) && (!out_valid_q || st.pop_ready);
  assign st.pop_valid = out_valid_q;
  assign st.pop_data  = out_data_q;

  // ==========================================================================
  // Storage
  always_ff @(posedge core_clk_in) begin
    if (ce_in && push) begin
      mem_q[wr_ptr_q] <= st.push_data;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else if (ce_in) begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (load) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      case ({push, load})
        2'b10:   count_q <= count_q + 1'b1;
        2'b01:   count_q <= count_q - 1'b1;
        default: count_q <= count_q;
      endcase
    end
  end

  // ==========================================================================
  // Registered head word
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else if (ce_in) begin
      if (load) begin
        out_valid_q <= 1'b1;
        out_data_q  <= mem_q[rd_ptr_q];
      end else if (st.pop_ready) begin
        out_valid_q <= 1'b0;
      end
    end
  end

  chk_fifo_bounded: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in) count_q <= CNT_FULL)
    else $error("fifo count beyond depth");
  cov_fifo_full: cover property (@(posedge core_clk_in)
    disable iff (sys_rst_in) !st.push_ready && st.push_valid);

endmodule : icip_fifo

// [hw/icip_top.sv]
// Functional notes
// - Size registers steer the logic only while mode is 001, 010, 011, 111.
// - Mode clears itself when done; host leaves sizes alone meanwhile.
// - Reset clears width and height to zero.
// - In an active mode each entry write is the next input word.
// - Reset clears the entry register to zero.
// - Words land one after another from the base, base register unchanged.
// - Base is a word address A22..A1, split upper and lower fields.
//
// The Wishbone register port is this design's own decision.
module icip_top
  import icip_pkg::*;
(
  input  wire logic                core_clk_in,  // System clock
  input  wire logic                sys_rst_in,   // Synchronous reset, high
  input  wire logic                ce_in,        // Clock enable
  input  wire logic                wb_cyc_in,    // Bus cycle
  input  wire logic                wb_stb_in,    // Bus strobe
  input  wire logic                wb_we_in,     // Bus write
  input  wire logic [WB_ADR_W-1:0] wb_adr_in,    // Byte address
  input  wire logic [3:0]          wb_sel_in,    // Byte enables
  input  wire logic [WB_DAT_W-1:0] wb_dat_in,    // Write data
  output logic      [WB_DAT_W-1:0] wb_dat_out,   // Read data
  output logic                     wb_ack_out,   // Bus acknowledge
  output logic                     cvt_valid_out, // Output word valid
  input  wire logic                cvt_ready_in, // Output word taken
  output logic      [ENTRY_W-1:0]  cvt_data_out, // Image word
  output logic      [DADDR_W-1:0]  cvt_addr_out, // Word address
  output logic      [MODE_W-1:0]   cvt_mode_out  // Mode of the word
);

  logic [HSIZE_W-1:0]  width_q;
  logic [VSIZE_W-1:0]  height_q;
  logic [ENTRY_W-1:0]  entry_q;
  logic [MODE_W-1:0]   mode_q;
  logic [DHI_W-1:0]    dest_hi_q;
  logic [DLO_W-1:0]    dest_lo_q;
  logic [HSIZE_W-1:0]  x_cnt_q;
  logic [VSIZE_W-1:0]  y_cnt_q;
  logic [DADDR_W-1:0]  word_idx_q;
  logic                ack_q;
  logic [WB_DAT_W-1:0] rdata_q;
  logic [WB_DAT_W-1:0] rd_mux;
  logic [IDX_W-1:0]    reg_idx;
  logic                req;
  logic                active;
  logic                sel_dest_hi;
  logic                sel_dest_lo;
  logic                sel_width;
  logic                sel_height;
  logic                sel_mode;
  logic                sel_status;
  logic                entry_wr;
  logic                entry_take;
  logic                take;
  logic                wr;
  logic                last_word;
  logic                empty_size;
  logic [ENTRY_W-1:0]  entry_word;
  logic [15:0]         wlo;
  logic [DADDR_W-1:0]  push_addr;
  logic [15:0]         width_mrg;
  logic [15:0]         height_mrg;
  logic [15:0]         dest_lo_mrg;

  icip_stream_if #(.WIDTH(ITEM_W)) fifo_if ();

  icip_fifo #(
    .WIDTH (ITEM_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .ce_in       (ce_in),
    .st          (fifo_if.store)
  );

  // ==========================================================================
  // Address decode
  assign reg_idx = wb_adr_in[WB_ADR_W-1:2];
  assign req     = wb_cyc_in && wb_stb_in && !ack_q;
  assign active  = icip_mode_active(mode_q);
  assign wlo     = wb_dat_in[15:0];

  always_comb begin
    sel_dest_hi = 1'b0;
    sel_dest_lo = 1'b0;
    sel_width   = 1'b0;
    sel_height  = 1'b0;
    sel_mode    = 1'b0;
    sel_status  = 1'b0;
    if (reg_idx == IDX_DEST_HI) begin
      sel_dest_hi = 1'b1;
    end else if (reg_idx == IDX_DEST_LO) begin
      sel_dest_lo = 1'b1;
    end else if (reg_idx == IDX_WIDTH) begin
      sel_width = 1'b1;
    end else if (reg_idx == IDX_HEIGHT) begin
      sel_height = 1'b1;
    end else if (reg_idx == IDX_MODE) begin
      sel_mode = 1'b1;
    end else if (reg_idx == IDX_STATUS) begin
      sel_status = 1'b1;
    end
  end

  // Shared index: entry word while active, height while idle
  assign entry_wr   = req && wb_we_in && sel_height && active;
  assign entry_take = entry_wr && fifo_if.push_ready;
  assign take       = req && !(entry_wr && !fifo_if.push_ready);
  assign wr         = take && wb_we_in;
  assign entry_word = icip_merge16(entry_q, wlo, wb_sel_in[1:0]);
  assign last_word  = (x_cnt_q == width_q - 1'b1) &&
                      (y_cnt_q == height_q - 1'b1);
  assign empty_size = (width_q == '0) || (height_q == '0);

  // Byte-merged register images, cut to field width below
  assign width_mrg   = icip_merge16({5'h0, width_q}, wlo, wb_sel_in[1:0]);
  assign height_mrg  = icip_merge16({6'h0, height_q}, wlo, wb_sel_in[1:0]);
  assign dest_lo_mrg = icip_merge16({dest_lo_q, 1'b0}, wlo, wb_sel_in[1:0]);

  // ==========================================================================
  // Bus answer
  always_comb begin
    rd_mux = '0;
    if (sel_dest_hi) begin
      rd_mux[DHI_LSB +: DHI_W] = dest_hi_q;
    end else if (sel_dest_lo) begin
      rd_mux[DLO_LSB +: DLO_W] = dest_lo_q;
    end else if (sel_width) begin
      rd_mux[HSIZE_LSB +: HSIZE_W] = width_q;
    end else if (sel_height) begin
      rd_mux[VSIZE_LSB +: VSIZE_W] = height_q;
    end else if (sel_mode) begin
      rd_mux[MODE_LSB +: MODE_W] = mode_q;
    end else if (sel_status) begin
      rd_mux[ST_BUSY_BIT] = active;
      rd_mux[ST_PEND_BIT] = fifo_if.pop_valid;
      rd_mux[ST_ROOM_BIT] = fifo_if.push_ready;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ack_q <= 1'b0;
    end else if (ce_in) begin
      ack_q <= take;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= '0;
    end else if (ce_in && take) begin
      rdata_q <= wb_we_in ? '0 : rd_mux;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdata_q;

  // ==========================================================================
  // Size registers
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      width_q  <= WIDTH_RST;
      height_q <= HEIGHT_RST;
    end else if (ce_in) begin
      if (wr && sel_width) begin
        width_q <= width_mrg[HSIZE_W-1:0];
      end
      if (wr && sel_height && !active) begin
        height_q <= height_mrg[VSIZE_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Destination base, never stepped by the transfer
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      dest_hi_q <= DEST_HI_RST;
      dest_lo_q <= DEST_LO_RST;
    end else if (ce_in) begin
      if (wr && sel_dest_hi && wb_sel_in[0]) begin
        dest_hi_q <= wlo[DHI_LSB +: DHI_W];
      end
      if (wr && sel_dest_lo) begin
        dest_lo_q <= dest_lo_mrg[15:DLO_LSB];
      end
    end
  end

  // ==========================================================================
  // Mode register with automatic clear
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      mode_q <= MODE_RST;
    end else if (ce_in) begin
      if (wr && sel_mode && wb_sel_in[0]) begin
        mode_q <= wlo[MODE_LSB +: MODE_W];
      end else if (active && ((entry_take && last_word) || empty_size)) begin
        mode_q <= MODE_OFF;
      end
    end
  end

  // ==========================================================================
  // Entry register
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      entry_q <= ENTRY_RST;
    end else if (ce_in && entry_take) begin
      entry_q <= entry_word;
    end
  end

  // ==========================================================================
  // Pixel and line counters
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      x_cnt_q    <= '0;
      y_cnt_q    <= '0;
      word_idx_q <= '0;
    end else if (ce_in) begin
      if (!active || (wr && sel_mode)) begin
        x_cnt_q    <= '0;
        y_cnt_q    <= '0;
        word_idx_q <= '0;
      end else if (entry_take) begin
        word_idx_q <= word_idx_q + 1'b1;
        if (x_cnt_q == width_q - 1'b1) begin
          x_cnt_q <= '0;
          y_cnt_q <= y_cnt_q + 1'b1;
        end else begin
          x_cnt_q <= x_cnt_q + 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Output path through the FIFO
  assign push_addr = {dest_hi_q, dest_lo_q} + word_idx_q;
  assign fifo_if.push_valid = entry_wr;
  assign fifo_if.push_data  = {mode_q, push_addr, entry_word};
  assign fifo_if.pop_ready  = cvt_ready_in;
  assign cvt_valid_out = fifo_if.pop_valid;
  assign cvt_data_out  = fifo_if.pop_data[ENTRY_W-1:0];
  assign cvt_addr_out  = fifo_if.pop_data[ENTRY_W +: DADDR_W];
  assign cvt_mode_out  = fifo_if.pop_data[ENTRY_W+DADDR_W +: MODE_W];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_idle_counters_zero: assert property (
    !active && ce_in |=> x_cnt_q == '0 && y_cnt_q == '0 && word_idx_q == '0)
    else $error("counters move while idle");
  chk_size_reset: assert property (disable iff (1'b0)
    sys_rst_in |=> width_q == WIDTH_RST && height_q == HEIGHT_RST)
    else $error("sizes not cleared by reset");
  chk_entry_reset: assert property (disable iff (1'b0)
    sys_rst_in |=> entry_q == ENTRY_RST)
    else $error("entry not cleared by reset");
  chk_entry_accepted: assert property (
    entry_take && ce_in |=> entry_q == $past(entry_word) && wb_ack_out)
    else $error("entry word not taken");
  chk_mode_auto_clear: assert property (
    active && entry_take && last_word && ce_in |=> mode_q == MODE_OFF)
    else $error("mode not cleared after last word");
  chk_base_kept: assert property (
    active && !(wr && ce_in && (sel_dest_hi || sel_dest_lo))
    |=> $stable(dest_hi_q) && $stable(dest_lo_q))
    else $error("base moved during transfer");
  chk_first_at_base: assert property (
    entry_take && word_idx_q == '0
    |-> fifo_if.push_data[ENTRY_W +: DADDR_W] == {dest_hi_q, dest_lo_q})
    else $error("first word not at base");
  chk_idle_entry_drop: assert property (
    req && wb_we_in && sel_height && !active |-> !fifo_if.push_valid)
    else $error("idle entry write pushed");
  chk_ack_single: assert property (
    wb_ack_out && ce_in |=> !wb_ack_out)
    else $error("ack held two cycles");

  cov_conversion_done: cover property (
    active ##1 mode_q == MODE_OFF);
  cov_entry_stall: cover property (
    entry_wr && !fifo_if.push_ready);
  cov_halfx_mode: cover property (
    wr && sel_mode && wlo[MODE_W-1:0] == MODE_HALFX);

endmodule : icip_top

// [include/icip_pkg.sv]
package icip_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned WB_ADR_W = 12;
  localparam int unsigned WB_DAT_W = 32;
  localparam int unsigned HSIZE_W  = 11;
  localparam int unsigned VSIZE_W  = 10;
  localparam int unsigned MODE_W   = 3;
  localparam int unsigned ENTRY_W  = 16;
  localparam int unsigned DHI_W    = 7;
  localparam int unsigned DLO_W    = 15;
  localparam int unsigned DADDR_W  = DHI_W + DLO_W;
  localparam int unsigned IDX_W    = 10;
  localparam int unsigned ITEM_W   = MODE_W + DADDR_W + ENTRY_W;
  localparam int unsigned FIFO_DEPTH = 4;

  // ==========================================================================
  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DEST_HI = 10'h042;
  localparam logic [IDX_W-1:0] IDX_DEST_LO = 10'h044;
  localparam logic [IDX_W-1:0] IDX_WIDTH   = 10'h046;
  localparam logic [IDX_W-1:0] IDX_HEIGHT  = 10'h048;
  localparam logic [IDX_W-1:0] IDX_ENTRY   = 10'h048;
  localparam logic [IDX_W-1:0] IDX_MODE    = 10'h04A;
  localparam logic [IDX_W-1:0] IDX_STATUS  = 10'h04C;

  // ==========================================================================
  // Field positions
  localparam int unsigned DHI_LSB     = 0;
  localparam int unsigned DLO_LSB     = 1;
  localparam int unsigned HSIZE_LSB   = 0;
  localparam int unsigned VSIZE_LSB   = 0;
  localparam int unsigned MODE_LSB    = 0;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_PEND_BIT = 1;
  localparam int unsigned ST_ROOM_BIT = 2;

  // ==========================================================================
  // Reset values
  localparam logic [HSIZE_W-1:0] WIDTH_RST   = 11'h000;
  localparam logic [VSIZE_W-1:0] HEIGHT_RST  = 10'h000;
  localparam logic [ENTRY_W-1:0] ENTRY_RST   = 16'h0000;
  localparam logic [DHI_W-1:0]   DEST_HI_RST = 7'h00;
  localparam logic [DLO_W-1:0]   DEST_LO_RST = 15'h0000;
  localparam logic [MODE_W-1:0]  MODE_RST    = 3'h0;

  // ==========================================================================
  // Conversion mode codes
  localparam logic [MODE_W-1:0] MODE_OFF   = 3'h0;
  localparam logic [MODE_W-1:0] MODE_CVT1  = 3'h1;
  localparam logic [MODE_W-1:0] MODE_CVT2  = 3'h2;
  localparam logic [MODE_W-1:0] MODE_CVT3  = 3'h3;
  localparam logic [MODE_W-1:0] MODE_HALFX = 3'h7;

  function automatic logic icip_mode_active(input logic [MODE_W-1:0] m);
    return (m == MODE_CVT1) || (m == MODE_CVT2) || (m == MODE_CVT3) ||
           (m == MODE_HALFX);
  endfunction : icip_mode_active

  function automatic logic [15:0] icip_merge16(input logic [15:0] old_v,
                                               input logic [15:0] new_v,
                                               input logic [1:0]  sel);
    return {sel[1] ? new_v[15:8] : old_v[15:8],
            sel[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction : icip_merge16

endpackage : icip_pkg

// [include/icip_stream_if.sv]
interface icip_stream_if #(
  parameter int unsigned WIDTH = 8
);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport store (input push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data);
  modport user  (output push_valid, push_data, pop_ready,
                 input push_ready, pop_valid, pop_data);
endinterface : icip_stream_if

// [verif/icip_host_model.sv]
module icip_host_model
  import icip_pkg::*;
(
  input  wire logic                core_clk_in, // System clock
  input  wire logic                wb_ack_in,   // Bus acknowledge
  input  wire logic [WB_DAT_W-1:0] wb_dat_in,   // Read data
  output logic                     wb_cyc_out,  // Bus cycle
  output logic                     wb_stb_out,  // Bus strobe
  output logic                     wb_we_out,   // Bus write
  output logic      [WB_ADR_W-1:0] wb_adr_out,  // Byte address
  output logic      [3:0]          wb_sel_out,  // Byte enables
  output logic      [WB_DAT_W-1:0] wb_dat_out   // Write data
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    wb_cyc_out = 1'b0;
    wb_stb_out = 1'b0;
    wb_we_out  = 1'b0;
    wb_adr_out = 12'h000;
    wb_sel_out = 4'h0;
    wb_dat_out = 32'h00000000;
  end

  // ==========================================================================
  // Classic single cycle, held until ack is sampled
  task automatic access(input logic wr, input logic [WB_ADR_W-1:0] adr,
                        input logic [WB_DAT_W-1:0] wdat,
                        output logic [WB_DAT_W-1:0] rdat);
    @(posedge core_clk_in);
    wb_cyc_out <= 1'b1;
    wb_stb_out <= 1'b1;
    wb_we_out  <= wr;
    wb_adr_out <= adr;
    wb_sel_out <= 4'hF;
    wb_dat_out <= wdat;
    do @(posedge core_clk_in); while (wb_ack_in !== 1'b1);
    rdat = wb_dat_in;
    wb_cyc_out <= 1'b0;
    wb_stb_out <= 1'b0;
    // Released lines carry no stale value
    wb_adr_out <= ~adr;
    wb_dat_out <= ~wdat;
  endtask : access

  task automatic write(input logic [WB_ADR_W-1:0] adr,
                       input logic [WB_DAT_W-1:0] wdat);
    logic [WB_DAT_W-1:0] unused;
    access(1'b1, adr, wdat, unused);
  endtask : write

  task automatic read(input logic [WB_ADR_W-1:0] adr,
                      output logic [WB_DAT_W-1:0] rdat);
    access(1'b0, adr, 32'h00000000, rdat);
  endtask : read

  // ==========================================================================
  // Sizes first, then activation; caller waits for idle before the next
  task automatic setup(input int pixels, input int lines,
                       input logic [MODE_W-1:0] mode);
    logic [HSIZE_W-1:0] w;
    w = (mode == MODE_HALFX) ? HSIZE_W'(pixels / 2) : HSIZE_W'(pixels);
    w[0] = 1'b0;
    write(12'h118, {21'h00000, w});
    write(12'h120, {22'h00000, VSIZE_W'(lines)});
    write(12'h128, {29'h0000000, mode});
  endtask : setup
endmodule : icip_host_model

// [verif/tb_top.sv]
module tb_top;
  import icip_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [WB_ADR_W-1:0] A_HI  = 12'h108;
  localparam logic [WB_ADR_W-1:0] A_LO  = 12'h110;
  localparam logic [WB_ADR_W-1:0] A_W   = 12'h118;
  localparam logic [WB_ADR_W-1:0] A_H   = 12'h120;
  localparam logic [WB_ADR_W-1:0] A_M   = 12'h128;
  localparam logic [WB_ADR_W-1:0] A_ST  = 12'h130;
  localparam logic [WB_ADR_W-1:0] A_BAD = 12'h200;
  localparam logic [MODE_W-1:0] ACT_M[4] = '{MODE_CVT1, MODE_CVT2,
                                             MODE_CVT3, MODE_HALFX};
  localparam logic [MODE_W-1:0] IDLE_M[4] = '{MODE_OFF, 3'h4, 3'h5, 3'h6};

  logic                clk;
  logic                rst;
  logic                ce;
  logic                ready;
  logic                sink_on;
  logic                stall;
  logic                cyc;
  logic                stb;
  logic                we;
  logic [WB_ADR_W-1:0] adr;
  logic [3:0]          sel;
  logic [WB_DAT_W-1:0] wdat;
  logic [WB_DAT_W-1:0] rdat;
  logic                ack;
  logic                cvt_valid;
  logic [ENTRY_W-1:0]  cvt_data;
  logic [DADDR_W-1:0]  cvt_addr;
  logic [MODE_W-1:0]   cvt_mode;
  logic [ITEM_W-1:0]   got_q[$];
  int                  cycles;
  int                  acks;
  int                  bad_count;
  int                  checks_done;

  icip_top DUT (
    .core_clk_in(clk), .sys_rst_in(rst), .ce_in(ce),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .cvt_valid_out(cvt_valid), .cvt_ready_in(ready),
    .cvt_data_out(cvt_data), .cvt_addr_out(cvt_addr),
    .cvt_mode_out(cvt_mode)
  );

  icip_host_model host (
    .core_clk_in(clk), .wb_ack_in(ack), .wb_dat_in(rdat),
    .wb_cyc_out(cyc), .wb_stb_out(stb), .wb_we_out(we),
    .wb_adr_out(adr), .wb_sel_out(sel), .wb_dat_out(wdat)
  );

  // ==========================================================================
  // Clock, downstream sink, ack counter, timeout
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (!rst && ce === 1'b1 && cvt_valid === 1'b1 && ready === 1'b1)
      got_q.push_back({cvt_mode, cvt_addr, cvt_data});
    if (ack === 1'b1)
      acks <= acks + 1;
    ready <= sink_on && (!stall || cycles[1:0] == 2'h0);
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Compare and helper tasks
  task automatic chk_val(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  task automatic chk_word(input logic [ITEM_W-1:0] exp);
    logic [ITEM_W-1:0] got;
    got = (got_q.size() > 0) ? got_q.pop_front() : 'x;
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] stream word expected %h seen %h", exp, got);
    end
  endtask : chk_word

  task automatic chk_reg(input string name, input logic [WB_ADR_W-1:0] a,
                         input logic [31:0] exp);
    logic [31:0] v;
    host.read(a, v);
    chk_val(name, exp, v);
  endtask : chk_reg

  task automatic wait_words(input int n);
    for (int i = 0; i < 500 && got_q.size() < n; i++)
      @(posedge clk);
  endtask : wait_words

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    chk_reg("width", A_W, 32'h0);
    chk_reg("height", A_H, 32'h0);
    chk_reg("mode", A_M, 32'h0);
    chk_reg("status", A_ST, 32'h4);
    chk_val("entry word", 32'h0, {16'h0000, cvt_data});
  endtask : t_reset

  task automatic t_regs();
    host.write(A_HI, 32'h7F);
    chk_reg("dest_hi", A_HI, 32'h7F);
    host.write(A_LO, 32'hFFFF);
    chk_reg("dest_lo", A_LO, 32'hFFFE);
    host.write(A_W, 32'h7FE);
    chk_reg("width", A_W, 32'h7FE);
    host.write(A_M, 32'h1);
    chk_reg("mode empty size", A_M, 32'h0);
    host.write(A_BAD, 32'h1234);
    chk_reg("unmapped", A_BAD, 32'h0);
  endtask : t_regs

  task automatic t_idle();
    foreach (IDLE_M[i]) begin
      host.write(A_M, {29'h0, IDLE_M[i]});
      host.write(A_H, 32'h155);
      chk_reg("height idle", A_H, 32'h155);
      repeat (10) @(posedge clk);
      chk_val("idle words", 32'h0, got_q.size());
    end
    host.write(A_M, 32'h0);
  endtask : t_idle

  task automatic t_convert(input logic [MODE_W-1:0] m);
    int n;
    logic [DADDR_W-1:0] base;
    n = (m == MODE_HALFX) ? 4 : 8;
    base = {7'h12, 15'h7FFE};
    got_q.delete();
    host.write(A_HI, 32'h12);
    host.write(A_LO, 32'hFFFC);
    host.setup(4, 2, m);
    chk_reg("status busy", A_ST, 32'h5);
    for (int i = 0; i < n; i++)
      host.write(A_H, 32'hC000 + i);
    wait_words(n);
    for (int i = 0; i < n; i++)
      chk_word({m, base + DADDR_W'(i), 16'hC000 + 16'(i)});
    chk_reg("mode after", A_M, 32'h0);
    chk_reg("dest_lo kept", A_LO, 32'hFFFC);
    chk_val("extra words", 32'h0, got_q.size());
  endtask : t_convert

  task automatic t_stall();
    got_q.delete();
    sink_on <= 1'b0;
    host.setup(4, 2, MODE_CVT1);
    @(posedge clk);
    acks <= 0;
    fork
      for (int i = 0; i < 8; i++)
        host.write(A_H, 32'h5A00 + i);
      begin
        repeat (60) @(posedge clk);
        chk_val("stalled acks", 32'h5, acks);
        ce <= 1'b0;
        sink_on <= 1'b1;
        repeat (8) @(posedge clk);
        chk_val("frozen head", 32'h5A00, {16'h0000, cvt_data});
        ce <= 1'b1;
        stall <= 1'b1;
      end
    join
    wait_words(8);
    for (int i = 0; i < 8; i++)
      chk_word({MODE_CVT1, 22'h97FFE + 22'(i), 16'h5A00 + 16'(i)});
    chk_reg("mode after", A_M, 32'h0);
    stall <= 1'b0;
  endtask : t_stall

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    ready = 1'b0;
    sink_on = 1'b1;
    stall = 1'b0;
    cycles = 0;
    acks = 0;
    bad_count = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_idle();
    foreach (ACT_M[i])
      t_convert(ACT_M[i]);
    t_stall();
    print_verdict();
  end
endmodule : tb_top
